// ### design/malu_defines.vh
// constants for the mac address lookup and learning unit
`ifndef MALU_DEFINES_VH
`define MALU_DEFINES_VH

// =====================================================================
// entry layout inside one bin (dpv sits above, width = port count)
`define MALU_MAC_LSB      0
`define MALU_MAC_W        48
`define MALU_DB_LSB       48
`define MALU_DB_W         4
`define MALU_ST_LSB       52
`define MALU_ST_W         4
`define MALU_DPV_LSB      56
`define MALU_MCAST_BIT    40
`define MALU_BINS         4

// =====================================================================
// entry states
`define MALU_ST_EMPTY     4'h0
`define MALU_ST_FRESH     4'hE
`define MALU_ST_LOCKED    4'hF

// =====================================================================
// table size select and the matching location masks
`define MALU_SIZE_256     2'b00
`define MALU_SIZE_512     2'b01
`define MALU_SIZE_1024    2'b10
`define MALU_SIZE_RST     2'b10
`define MALU_MASK_256     8'h3F
`define MALU_MASK_512     8'h7F
`define MALU_MASK_1024    8'hFF
`define MALU_LOC_LAST     8'hFF

// =====================================================================
// port forwarding states
`define MALU_PS_DISABLED  2'b00
`define MALU_PS_BLOCKING  2'b01
`define MALU_PS_LEARNING  2'b10
`define MALU_PS_FORWARD   2'b11

// =====================================================================
// aging timing: one sweep per (age_interval * 16 s / 14)
`define MALU_AGE_DEFAULT  8'h13
`define MALU_AGE_STEP_S   64'd16
`define MALU_AGE_STATES   64'd14
`define MALU_CLK_HZ       64'd250000000
`define MALU_SWEEP_UNIT_CYC ((`MALU_AGE_STEP_S * `MALU_CLK_HZ) / `MALU_AGE_STATES)

`endif

// ### design/malu_bin_ram.v
// location memory holding four address bins per word
`timescale 1ns/1ps

module malu_bin_ram #(
	parameter AW = 8,
	parameter DW = 256
) (
	input  wire          clk,
	input  wire [AW-1:0] rd_addr,
	output reg  [DW-1:0] rd_data,
	input  wire          wr_en,
	input  wire [AW-1:0] wr_addr,
	input  wire [DW-1:0] wr_data
);

	reg [DW-1:0] mem [0:(1<<AW)-1];

	// one synchronous read and one write per cycle
	always @(posedge clk) begin
		rd_data <= mem[rd_addr];
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

endmodule

// ### design/malu_lookup.v
// destination lookup, source learning and aging engine
`timescale 1ns/1ps
`include "malu_defines.vh"

// What this block does
// - one destination lookup plus source learn per frame, far under minimum frame time
// - hash 48-bit address to a location of four bins, compare every bin
// - table size 256, 512 or 1024 entries, 1024 after reset
// - age interval in 16 s steps up to 4080 s, zero disables aging
// - new table size clears the whole table and pulses a soft reset
// - hit returns stored vector, miss floods to live ports except ingress
// - port lookup requests are arbitrated, one serviced at a time
// - miss uses ingress port vlan map, hit vector is masked by it
// - multicast searched like unicast, multicast source never learned
// - only entries of the ingress port database can match
// - source miss inserts a new entry with state 0xE
// - source hit on an unlocked entry rewrites port mapping and refreshes state
// - a new entry goes into the first empty bin
// - full location replaces oldest unlocked bin, first on equal age
// - all four bins locked on a learnable source miss means no learn and a table full event
// - learned entry carries the ingress port database number
// - global learn disable stops learning on every port
// - no learning on disabled or blocking ports or zero association vector
// - state 0xF is a locked entry that never ages, 0x0 is empty
// - each sweep decrements valid unlocked entries, zero means purged
module malu_lookup #(
	parameter        NP              = 6,
	parameter        PW              = 3,
	parameter [63:0] SWEEP_UNIT_CYC  = `MALU_SWEEP_UNIT_CYC
) (
	input  wire              clk,
	input  wire              resetn,
	input  wire [NP-1:0]     req_valid,
	input  wire [NP*48-1:0]  req_dest_addr,
	input  wire [NP*48-1:0]  req_src_addr,
	output reg  [NP-1:0]     req_ack_q,
	output reg               rsp_valid_q,
	output reg  [PW-1:0]     rsp_port_q,
	output reg               rsp_hit_q,
	output reg  [NP-1:0]     rsp_dest_port_vector_q,
	input  wire [1:0]        table_size_sel,
	input  wire [7:0]        age_interval,
	input  wire              learn_disable_all,
	input  wire [NP*4-1:0]   address_db_select,
	input  wire [NP*NP-1:0]  port_assoc_vector,
	input  wire [NP*2-1:0]   port_forward_state,
	input  wire [NP-1:0]     port_link_up,
	input  wire [NP*NP-1:0]  port_vlan_map,
	output reg               soft_reset_q,
	output reg               table_full_event_q,
	output reg               busy_q
);

	// =================================================================
	// sizes and states
	localparam EW = `MALU_DPV_LSB + NP;
	localparam DW = EW * `MALU_BINS;
	localparam [6:0] S_IDLE  = 7'b0000001;
	localparam [6:0] S_CLEAR = 7'b0000010;
	localparam [6:0] S_DRD   = 7'b0000100;
	localparam [6:0] S_DCMP  = 7'b0001000;
	localparam [6:0] S_SCMP  = 7'b0010000;
	localparam [6:0] S_ARD   = 7'b0100000;
	localparam [6:0] S_AWR   = 7'b1000000;

	reg  [6:0]    state_q;
	reg  [PW-1:0] port_q;
	reg  [PW-1:0] last_q;
	reg  [47:0]   da_q;
	reg  [47:0]   sa_q;
	reg  [1:0]    size_q;
	reg           clr_pend_q;
	reg           sweep_pend_q;
	reg           age_busy_q;
	reg           age_turn_q;
	reg  [7:0]    loc_q;
	reg  [31:0]   unit_cnt_q;
	reg  [7:0]    ivl_cnt_q;
	wire [DW-1:0] rd_data;
	reg  [7:0]    rd_addr;
	reg           wr_en;
	reg  [7:0]    wr_addr;
	reg  [DW-1:0] wr_data;

	// =================================================================
	// hash: xor fold of the six octets, cut to the table depth
	function [7:0] malu_hash;
		input [47:0] mac;
		input [7:0]  mask;
		begin
			malu_hash = (mac[7:0] ^ mac[15:8] ^ mac[23:16] ^ mac[31:24] ^
				mac[39:32] ^ mac[47:40]) & mask;
		end
	endfunction

	// location mask from the captured size
	reg [7:0] loc_mask;
	always @* begin
		case (size_q)
			`MALU_SIZE_256: loc_mask = `MALU_MASK_256;
			`MALU_SIZE_512: loc_mask = `MALU_MASK_512;
			default:        loc_mask = `MALU_MASK_1024;
		endcase
	end

	// =================================================================
	// ingress port attributes
	wire [3:0]    port_db   = address_db_select[port_q*4 +: 4];
	wire [NP-1:0] port_pav  = port_assoc_vector[port_q*NP +: NP];
	wire [NP-1:0] port_vlan = port_vlan_map[port_q*NP +: NP];
	wire [1:0]    port_fs   = port_forward_state[port_q*2 +: 2];
	wire [47:0]   key       = state_q[3] ? da_q : sa_q;

	// flood set: link up, not disabled, not the ingress port
	wire [NP-1:0] flood;
	genvar gp;
	generate
		for (gp = 0; gp < NP; gp = gp + 1) begin : g_flood
			assign flood[gp] = port_link_up[gp] &&
				(port_forward_state[gp*2 +: 2] != `MALU_PS_DISABLED) &&
				(port_q != gp);
		end
	endgenerate

	// =================================================================
	// per-bin decode and compare
	wire [3:0]          b_hit;
	wire [3:0]          b_empty;
	wire [3:0]          b_locked;
	wire [4*4-1:0]      b_st;
	wire [4*NP-1:0]     b_dpv;
	wire [DW-1:0]       aged;
	genvar gb;
	generate
		for (gb = 0; gb < `MALU_BINS; gb = gb + 1) begin : g_bin
			wire [EW-1:0] ent = rd_data[gb*EW +: EW];
			wire [3:0]    st  = ent[`MALU_ST_LSB +: 4];
			assign b_st[gb*4 +: 4]   = st;
			assign b_dpv[gb*NP +: NP] = ent[`MALU_DPV_LSB +: NP];
			assign b_empty[gb]  = (st == `MALU_ST_EMPTY);
			assign b_locked[gb] = (st == `MALU_ST_LOCKED);
			assign b_hit[gb] = !b_empty[gb] && (ent[`MALU_MAC_LSB +: 48] == key) &&
				(ent[`MALU_DB_LSB +: 4] == port_db);
			// locked and empty entries keep their state across a sweep
			assign aged[gb*EW +: EW] = (b_empty[gb] || b_locked[gb]) ? ent :
				{ent[EW-1:`MALU_ST_LSB+4], st - 4'h1, ent[`MALU_ST_LSB-1:0]};
		end
	endgenerate

	// =================================================================
	// first matching bin and replacement choice
	reg  [1:0]    hit_idx;
	reg  [1:0]    vic_idx;
	reg  [3:0]    best_st;
	reg           vic_found;
	integer       i;
	always @* begin
		hit_idx   = 2'd0;
		vic_idx   = 2'd0;
		best_st   = 4'h0;
		vic_found = 1'b0;
		for (i = `MALU_BINS - 1; i >= 0; i = i - 1) begin
			if (b_hit[i]) begin
				hit_idx = i[1:0];
			end
		end
		if (|b_hit) begin
			vic_idx   = hit_idx;
			vic_found = !b_locked[hit_idx];
		end else if (|b_empty) begin
			for (i = `MALU_BINS - 1; i >= 0; i = i - 1) begin
				if (b_empty[i]) begin
					vic_idx = i[1:0];
				end
			end
			vic_found = 1'b1;
		end else begin
			// strict compare keeps the first bin among equal ages
			for (i = 0; i < `MALU_BINS; i = i + 1) begin
				if (!b_locked[i] && (!vic_found || (b_st[i*4 +: 4] < best_st))) begin
					vic_idx   = i[1:0];
					best_st   = b_st[i*4 +: 4];
					vic_found = 1'b1;
				end
			end
		end
	end

	// learn gate for the ingress port and source address
	wire learn_ok = !learn_disable_all &&
		!sa_q[`MALU_MCAST_BIT] &&
		(port_fs != `MALU_PS_DISABLED) && (port_fs != `MALU_PS_BLOCKING) &&
		(port_pav != {NP{1'b0}});
	wire all_locked = (&b_locked);
	wire [EW-1:0] new_ent = {port_pav, `MALU_ST_FRESH, port_db, sa_q};

	// =================================================================
	// round robin grant among requesting ports
	reg  [PW-1:0] gnt_idx;
	reg           gnt_any;
	integer       k;
	integer       idx;
	always @* begin
		gnt_idx = {PW{1'b0}};
		gnt_any = 1'b0;
		idx     = 0;
		for (k = NP; k >= 1; k = k - 1) begin
			idx = (last_q + k) % NP;
			if (req_valid[idx] && !req_ack_q[idx]) begin
				gnt_idx = idx[PW-1:0];
				gnt_any = 1'b1;
			end
		end
	end

	wire clr_start = state_q[0] && clr_pend_q;
	wire age_go    = state_q[0] && !clr_pend_q && age_busy_q && (age_turn_q || !gnt_any);
	wire sweep_go  = state_q[0] && !clr_pend_q && !age_busy_q && sweep_pend_q;
	wire size_chg  = (table_size_sel != size_q);

	// =================================================================
	// memory port steering
	always @* begin
		rd_addr = loc_q;
		wr_en   = 1'b0;
		wr_addr = loc_q;
		wr_data = {DW{1'b0}};
		case (state_q)
			S_DRD:   rd_addr = malu_hash(da_q, loc_mask);
			S_DCMP:  rd_addr = malu_hash(sa_q, loc_mask);
			S_CLEAR: wr_en = 1'b1;
			S_AWR: begin
				wr_en   = 1'b1;
				wr_data = aged;
			end
			S_SCMP: begin
				wr_en   = learn_ok && vic_found;
				wr_addr = malu_hash(sa_q, loc_mask);
				wr_data = rd_data;
				wr_data[vic_idx*EW +: EW] = new_ent;
			end
			default: rd_addr = loc_q;
		endcase
	end

	malu_bin_ram #(
		.AW (8),
		.DW (DW)
	) u_ram (
		.clk     (clk),
		.rd_addr (rd_addr),
		.rd_data (rd_data),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data)
	);

	// =================================================================
	// age timer: a sweep every age_interval units of 16/14 s
	always @(posedge clk) begin
		if (!resetn) begin
			unit_cnt_q   <= 32'h0000_0000;
			ivl_cnt_q    <= 8'h00;
			sweep_pend_q <= 1'b0;
		end else if (age_interval == 8'h00) begin
			unit_cnt_q   <= 32'h0000_0000;
			ivl_cnt_q    <= 8'h00;
			sweep_pend_q <= 1'b0;
		end else if (unit_cnt_q == SWEEP_UNIT_CYC[31:0] - 32'h0000_0001) begin
			unit_cnt_q <= 32'h0000_0000;
			if (ivl_cnt_q >= age_interval - 8'h01) begin
				ivl_cnt_q    <= 8'h00;
				sweep_pend_q <= 1'b1;
			end else begin
				ivl_cnt_q    <= ivl_cnt_q + 8'h01;
				sweep_pend_q <= sweep_pend_q && !sweep_go;
			end
		end else begin
			unit_cnt_q   <= unit_cnt_q + 32'h0000_0001;
			sweep_pend_q <= sweep_pend_q && !sweep_go;
		end
	end

	// =================================================================
	// main sequencer
	always @(posedge clk) begin
		if (!resetn) begin
			state_q                <= S_IDLE;
			port_q                 <= {PW{1'b0}};
			last_q                 <= {PW{1'b0}};
			da_q                   <= 48'h0000_0000_0000;
			sa_q                   <= 48'h0000_0000_0000;
			size_q                 <= `MALU_SIZE_RST;
			clr_pend_q             <= 1'b1;
			age_busy_q             <= 1'b0;
			age_turn_q             <= 1'b0;
			loc_q                  <= 8'h00;
			req_ack_q              <= {NP{1'b0}};
			rsp_valid_q            <= 1'b0;
			rsp_port_q             <= {PW{1'b0}};
			rsp_hit_q              <= 1'b0;
			rsp_dest_port_vector_q <= {NP{1'b0}};
			soft_reset_q           <= 1'b0;
			table_full_event_q     <= 1'b0;
			busy_q                 <= 1'b1;
		end else begin
			req_ack_q          <= {NP{1'b0}};
			rsp_valid_q        <= 1'b0;
			table_full_event_q <= 1'b0;
			soft_reset_q       <= size_chg;
			busy_q             <= clr_pend_q || state_q[1];
			if (size_chg) begin
				size_q <= table_size_sel;
			end
			// a new size request wins over the start of the clear
			clr_pend_q <= size_chg || (clr_pend_q && !clr_start);
			case (state_q)
				S_IDLE: begin
					if (clr_start) begin
						loc_q      <= 8'h00;
						age_busy_q <= 1'b0;
						state_q    <= S_CLEAR;
					end else if (age_go || sweep_go) begin
						if (sweep_go) begin
							loc_q <= 8'h00;
						end
						age_busy_q <= 1'b1;
						age_turn_q <= 1'b0;
						state_q    <= S_ARD;
					end else if (gnt_any) begin
						port_q             <= gnt_idx;
						last_q             <= gnt_idx;
						da_q               <= req_dest_addr[gnt_idx*48 +: 48];
						sa_q               <= req_src_addr[gnt_idx*48 +: 48];
						req_ack_q[gnt_idx] <= 1'b1;
						age_turn_q         <= 1'b1;
						state_q            <= S_DRD;
					end
				end
				S_CLEAR: begin
					loc_q <= loc_q + 8'h01;
					if (loc_q == `MALU_LOC_LAST) begin
						state_q <= S_IDLE;
					end
				end
				S_DRD: state_q <= S_DCMP;
				S_DCMP: begin
					rsp_valid_q <= 1'b1;
					rsp_port_q  <= port_q;
					rsp_hit_q   <= |b_hit;
					if (|b_hit) begin
						rsp_dest_port_vector_q <= b_dpv[hit_idx*NP +: NP] & port_vlan;
					end else begin
						rsp_dest_port_vector_q <= port_vlan & flood;
					end
					state_q <= S_SCMP;
				end
				S_SCMP: begin
					table_full_event_q <= learn_ok && !(|b_hit) && !(|b_empty) &&
						all_locked;
					state_q <= S_IDLE;
				end
				S_ARD: state_q <= S_AWR;
				S_AWR: begin
					loc_q <= loc_q + 8'h01;
					if (loc_q == loc_mask) begin
						age_busy_q <= 1'b0;
					end
					state_q <= S_IDLE;
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

endmodule

// ### testbench/malu_lookup_checker.sv
// port-level assertions for the lookup and learning unit
`timescale 1ns/1ps

// =====================================================================
// checker
module malu_lookup_checker #(
	parameter NP = 6,
	parameter PW = 3
) (
	input wire              clk,
	input wire              resetn,
	input wire [NP-1:0]     req_valid,
	input wire [NP-1:0]     req_ack_q,
	input wire              rsp_valid_q,
	input wire [PW-1:0]     rsp_port_q,
	input wire              rsp_hit_q,
	input wire [NP-1:0]     rsp_dest_port_vector_q,
	input wire [1:0]        table_size_sel,
	input wire              learn_disable_all,
	input wire [NP-1:0]     port_link_up,
	input wire [NP*NP-1:0]  port_vlan_map,
	input wire              soft_reset_q,
	input wire              table_full_event_q,
	input wire              busy_q
);
	localparam [NP-1:0] ONE = {{(NP-1){1'b0}}, 1'b1};

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// grant and answer sequencing
	chk_ack_single: assert property ($onehot0(req_ack_q))
		else $error("more than one port acknowledged");
	chk_ack_requested: assert property ((req_ack_q & ~$past(req_valid)) == '0)
		else $error("ack to a port without a request");
	chk_ack_spacing: assert property (|req_ack_q |=> (req_ack_q == '0) [*3])
		else $error("lookups granted closer than four cycles");
	chk_rsp_follows: assert property (|req_ack_q |-> ##2
		(rsp_valid_q && (ONE << rsp_port_q) == $past(req_ack_q, 2)))
		else $error("answer missing or for wrong port");

	// vector contents
	chk_vec_vlan: assert property (rsp_valid_q |->
		(rsp_dest_port_vector_q & ~port_vlan_map[rsp_port_q*NP +: NP]) == '0)
		else $error("vector outside ingress vlan map");
	chk_miss_flood: assert property (rsp_valid_q && !rsp_hit_q |->
		(rsp_dest_port_vector_q & (~port_link_up | (ONE << rsp_port_q))) == '0)
		else $error("flood reaches ingress or dead link");

	// size change, startup clear and table full
	chk_size_reset: assert property ($changed(table_size_sel) |=> soft_reset_q ##1 busy_q)
		else $error("size change without soft reset and clear");
	chk_reset_cause: assert property (soft_reset_q |->
		$past(table_size_sel, 2) != $past(table_size_sel))
		else $error("soft reset without size change");
	chk_busy_start: assert property ($past(!resetn) |-> busy_q)
		else $error("no table clear after reset");
	chk_full_learn: assert property (table_full_event_q |-> !learn_disable_all)
		else $error("table full while learning disabled");

	// main scenarios
	cov_hit: cover property (rsp_valid_q && rsp_hit_q);
	cov_miss: cover property (rsp_valid_q && !rsp_hit_q);
	cov_size: cover property (soft_reset_q);
	cov_contend: cover property (|req_ack_q && |(req_valid & ~req_ack_q));
endmodule

bind malu_lookup malu_lookup_checker #(.NP(NP), .PW(PW)) malu_lookup_checker_i (
	.clk, .resetn, .req_valid, .req_ack_q, .rsp_valid_q, .rsp_port_q, .rsp_hit_q,
	.rsp_dest_port_vector_q, .table_size_sel, .learn_disable_all, .port_link_up,
	.port_vlan_map, .soft_reset_q, .table_full_event_q, .busy_q);

// ### testbench/malu_port_model.sv
// port mac request side: holds each request until its acknowledge
`timescale 1ns/1ps

// =====================================================================
// request holder
module malu_port_model #(
	parameter NP = 6
) (
	input  wire          clk,
	input  wire          resetn,
	input  wire [NP-1:0] start,
	input  wire [NP-1:0] ack,
	output reg  [NP-1:0] req_valid
);
	// raise on start, drop at the edge that sees the ack
	always @(posedge clk) begin
		if (!resetn)
			req_valid <= {NP{1'b0}};
		else
			req_valid <= (req_valid | start) & ~ack;
	end
endmodule

// ### testbench/mac_address_lookup_learn_test.sv
// self-checking bench for the lookup and learning unit
`timescale 1ns/1ps

// =====================================================================
// bench top
module mac_address_lookup_learn_test;
	localparam NP = 6;
	localparam PW = 3;
	reg              clk = 1'b0;
	reg              resetn = 1'b0;
	reg  [NP-1:0]    st = 6'h00;
	reg  [NP*48-1:0] da = {(NP*48){1'b0}};
	reg  [NP*48-1:0] sa = {(NP*48){1'b0}};
	reg  [1:0]       size = 2'b10;
	reg  [7:0]       age = 8'h00;
	reg              lrn_dis = 1'b0;
	reg  [NP*4-1:0]  dbs = 24'h10_0000;
	reg  [NP*NP-1:0] assoc = {(NP*NP){1'b0}};
	reg  [NP*NP-1:0] vlan = {(NP*NP){1'b0}};
	reg  [NP*2-1:0]  fst = 12'hd3f;
	reg  [NP-1:0]    link = 6'h3f;
	wire [NP-1:0]    rv;
	wire [NP-1:0]    ack;
	wire             rsp_v;
	wire [PW-1:0]    rsp_p;
	wire             rsp_h;
	wire [NP-1:0]    rsp_vec;
	wire             srst;
	wire             busy;
	wire             full;
	reg              full_seen = 1'b0;
	integer          seed = 44;
	integer          bad_count = 0;
	integer          cmp_count = 0;
	integer          cyc = 0;
	integer          i;
	integer          n;
	reg  [31:0]      r;
	reg  [NP-1:0]    seen;
	reg  [47:0]      a_mac, b_mac, e_mac, m_mac;

	always #2 clk = ~clk;

	// design and port model
	malu_lookup #(.NP(NP), .PW(PW), .SWEEP_UNIT_CYC(64'd20)) malu_lookup_i (
		.clk(clk), .resetn(resetn), .req_valid(rv), .req_dest_addr(da),
		.req_src_addr(sa), .req_ack_q(ack), .rsp_valid_q(rsp_v), .rsp_port_q(rsp_p),
		.rsp_hit_q(rsp_h), .rsp_dest_port_vector_q(rsp_vec), .table_size_sel(size),
		.age_interval(age), .learn_disable_all(lrn_dis), .address_db_select(dbs),
		.port_assoc_vector(assoc), .port_forward_state(fst), .port_link_up(link),
		.port_vlan_map(vlan), .soft_reset_q(srst), .table_full_event_q(full), .busy_q(busy));
	malu_port_model #(.NP(NP)) malu_port_model_i (
		.clk(clk), .resetn(resetn), .start(st), .ack(ack), .req_valid(rv));

	// =====================================================================
	// expectations
	function [NP-1:0] fl(input integer p);
		integer q;
		begin
			fl = vlan[p*NP +: NP] & link;
			fl[p] = 1'b0;
			for (q = 0; q < NP; q = q + 1)
				if (fst[q*2 +: 2] == 2'b00) fl[q] = 1'b0;
		end
	endfunction

	function [NP-1:0] hv(input integer o, input integer p);
		hv = assoc[o*NP +: NP] & vlan[p*NP +: NP];
	endfunction

	function [47:0] rmac(input m);
		begin
			r = $random(seed);
			rmac[47:16] = r;
			r = $random(seed);
			rmac[15:0] = r[15:0];
			rmac[40] = m;
		end
	endfunction

	// =====================================================================
	// tasks
	task chk(input [8*6-1:0] nm, input [63:0] e, input [63:0] g);
		begin
			cmp_count = cmp_count + 1;
			if (e !== g) begin
				bad_count = bad_count + 1;
				$display("BAD %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask

	task wait_idle;
		begin
			n = 0;
			@(negedge clk);
			while (busy !== 1'b0 && n < 1000) begin
				@(negedge clk);
				n = n + 1;
			end
			chk("busy", 0, busy);
		end
	endtask

	task lk(input integer p, input [47:0] d, input [47:0] s, input h, input [NP-1:0] v);
		begin
			@(posedge clk);
			da[p*48 +: 48] <= d;
			sa[p*48 +: 48] <= s;
			st[p] <= 1'b1;
			@(posedge clk);
			st <= 6'h00;
			n = 0;
			@(negedge clk);
			while (rsp_v !== 1'b1 && n < 700) begin
				@(negedge clk);
				n = n + 1;
			end
			chk("rspv", 1, rsp_v);
			chk("resp", {p[PW-1:0], h, v}, {rsp_p, rsp_h, rsp_vec});
			@(posedge clk);
			da[p*48 +: 48] <= ~d;
			sa[p*48 +: 48] <= ~s;
		end
	endtask

	task end_of_test;
		begin
			$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
			if (bad_count == 0 && cmp_count > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask

	// table full must stay quiet: no bin can be locked from the ports
	always @(negedge clk) begin
		if (resetn === 1'b1 && full !== 1'b0)
			full_seen <= 1'b1;
	end

	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			bad_count = bad_count + 1;
			end_of_test;
		end
	end

	// =====================================================================
	// main sequence
	initial begin
		for (i = 0; i < NP; i = i + 1) begin
			r = $random(seed);
			vlan[i*NP +: NP] = r[5:0];
			assoc[i*NP +: NP] = r[11:6] | 6'h01;
		end
		link = r[17:12] | 6'h07;
		a_mac = rmac(1'b0);
		b_mac = rmac(1'b0);
		e_mac = rmac(1'b0);
		m_mac = rmac(1'b1);
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		wait_idle;
		lk(0, b_mac, a_mac, 1'b0, fl(0));
		lk(1, a_mac, b_mac, 1'b1, hv(0, 1));
		lk(5, a_mac, m_mac, 1'b0, fl(5));
		lk(1, m_mac, b_mac, 1'b0, fl(1));
		$display("test search and learn done");
		lk(5, b_mac, a_mac, 1'b0, fl(5));
		lk(5, a_mac, b_mac, 1'b1, hv(5, 5));
		lk(2, a_mac, b_mac, 1'b1, hv(0, 2));
		$display("test databases done");
		@(posedge clk) lrn_dis <= 1'b1;
		lk(0, b_mac, e_mac, 1'b1, hv(2, 0));
		repeat (2) @(posedge clk);
		lrn_dis <= 1'b0;
		lk(1, e_mac, b_mac, 1'b0, fl(1));
		lk(4, b_mac, e_mac, 1'b1, hv(1, 4));
		lk(0, e_mac, b_mac, 1'b0, fl(0));
		lk(2, b_mac, a_mac, 1'b1, hv(0, 2));
		$display("test learn gating done");
		// three ports request in the same cycle
		@(posedge clk);
		for (i = 0; i < 3; i = i + 1) begin
			da[i*48 +: 48] <= a_mac;
			sa[i*48 +: 48] <= a_mac;
		end
		st <= 6'h07;
		@(posedge clk);
		st <= 6'h00;
		seen = 6'h00;
		for (n = 0; n < 200; n = n + 1) begin
			@(negedge clk);
			if (rsp_v === 1'b1) seen[rsp_p] = 1'b1;
		end
		chk("ports", 6'h07, seen);
		$display("test arbitration done");
		@(posedge clk) size <= 2'b01;
		@(posedge clk);
		@(negedge clk);
		chk("srst", 1'b1, srst);
		@(negedge clk);
		chk("busy", 1'b1, busy);
		wait_idle;
		lk(1, a_mac, e_mac, 1'b0, fl(1));
		$display("test size change done");
		@(posedge clk) age <= 8'h01;
		lk(0, b_mac, a_mac, 1'b0, fl(0));
		lk(2, a_mac, e_mac, 1'b1, hv(0, 2));
		repeat (10000) @(posedge clk);
		lk(2, a_mac, e_mac, 1'b0, fl(2));
		$display("test aging done");
		chk("full", 0, full_seen);
		end_of_test;
	end
endmodule
